// ==== logic/ut_baud_gen.sv ====
// Fractional baud pulse generator built around a single 16-bit counter
`timescale 1ns/10ps
`default_nettype none
module ut_baud_gen #(
  parameter int IW = ut_pkg::INT_DIV_W,
  parameter int FW = ut_pkg::FRAC_DIV_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ref_tick,
  input wire logic [IW-1:0] int_div,
  input wire logic [FW-1:0] frac_div,
  output logic baud_tick
);
  logic [IW-1:0] cnt, next_cnt;
  logic [FW-1:0] acc, next_acc;
  logic hold, next_hold, next_tick;
  logic carry;

  // Down count of n, plus one held reference tick when the accumulator carried;
  // the carry happens exactly f times in 64 and no pulse is ever skipped
  always_comb begin
    next_cnt = cnt;
    next_acc = acc;
    next_hold = hold;
    next_tick = 1'b0;
    carry = 1'b0;
    if (ref_tick && int_div != '0) begin
      if (cnt > 16'h0001) begin
        next_cnt = cnt - 16'h0001;
      end else if (hold) begin
        next_hold = 1'b0;
      end else begin
        next_tick = 1'b1;
        next_cnt = int_div;
        {carry, next_acc} = {1'b0, acc} + {1'b0, frac_div};
        next_hold = carry;
      end
    end
  end

  // Only one counter; the hold flag only stretches its terminal count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 16'h0001;
      acc <= '0;
      hold <= 1'b0;
      baud_tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      acc <= next_acc;
      hold <= next_hold;
      baud_tick <= next_tick;
    end
  end

  a_tick_reload: assert property (@(posedge clk) disable iff (!rst_n)
    baud_tick |-> cnt == $past(int_div)) else $error("reload value wrong at pulse");
  a_no_drop: assert property (@(posedge clk) disable iff (!rst_n)
    ref_tick && int_div != '0 && cnt == 16'h0001 && !hold |=> baud_tick)
    else $error("baud pulse dropped");
  a_frac_zero: assert property (@(posedge clk) disable iff (!rst_n)
    frac_div == '0 && $past(frac_div == '0) && baud_tick |-> !hold)
    else $error("stretch with zero fraction");
endmodule : ut_baud_gen
`default_nettype wire

// ==== logic/ut_pkg.sv ====
// Package: register map, field positions, reset values and timing counts for the transmitter
`default_nettype none
package ut_pkg;
  // Register byte offsets
  localparam logic [11:0] ADDR_DATA = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h018;
  localparam logic [11:0] ADDR_INT_DIV = 12'h024;
  localparam logic [11:0] ADDR_FRAC_DIV = 12'h028;
  localparam logic [11:0] ADDR_LINE_CTRL = 12'h02C;
  localparam logic [11:0] ADDR_CTRL = 12'h030;
  // Control register fields
  localparam int CTRL_TX_EN = 0;
  localparam int CTRL_FLOW_EN = 1;
  localparam int CTRL_DMA_SYNC = 2;
  localparam int CTRL_TX_DMA = 3;
  localparam logic [3:0] CTRL_RST = 4'h5;
  // Line control fields: word length code (5 + code bits) and second stop bit
  localparam int LCR_WLEN_LSB = 0;
  localparam int LCR_TWO_STOP = 2;
  localparam logic [2:0] LCR_RST = 3'h3;
  // Status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_EMPTY = 1;
  localparam int ST_FULL = 2;
  localparam int ST_RX_CLR = 3;
  localparam int ST_TC = 4;
  localparam int ST_LEVEL_LSB = 8;
  // Divisor widths and reset values
  localparam int INT_DIV_W = 16;
  localparam int FRAC_DIV_W = 6;
  localparam logic [15:0] INT_DIV_RST = 16'h0000;
  localparam logic [5:0] FRAC_DIV_RST = 6'h00;
  // Timing: baud pulses per bit, word length base, FIFO depth, reference divider
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
  localparam logic [2:0] WLEN_BASE_LAST = 3'h4;
  localparam int FIFO_DEPTH = 16;
  localparam int REF_CLK_MHZ = 100;
  localparam int PCLK_MHZ = 100;
  localparam int REF_DIV = PCLK_MHZ / REF_CLK_MHZ;
endpackage : ut_pkg
`default_nettype wire

// ==== logic/ut_sync.sv ====
// Two-stage synchroniser for a group of independent single-bit levels
`timescale 1ns/10ps
`default_nettype none
module ut_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // First stage feeds only the second stage to keep metastability contained
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= RST;
      q <= RST;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : ut_sync
`default_nettype wire

// ==== logic/ut_tx_top.sv ====
// Transmitter with APB registers, transmit FIFO, DMA clear crossing and fractional baud
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module ut_tx_top #(
  parameter int DEPTH = ut_pkg::FIFO_DEPTH,
  parameter int REF_DIV = ut_pkg::REF_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic clear_to_send_n,
  output logic txd,
  output logic tx_dma_req,
  input wire logic tx_dma_req_clear,
  input wire logic rx_dma_req_clear,
  input wire logic dma_terminal_count,
  output logic rx_dma_clear_synced
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH + 1);
  localparam int RW = (REF_DIV > 1) ? $clog2(REF_DIV) : 1;

  typedef enum logic [2:0] {UT_IDLE, UT_START, UT_DATA, UT_STOP, UT_DONE} ut_state_t;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : ptr_inc

  // Register state
  logic [3:0] ctrl, next_ctrl;
  logic [2:0] lcr, next_lcr;
  logic [15:0] int_div, next_int_div;
  logic [5:0] frac_div, next_frac_div;
  logic [31:0] next_prdata;
  logic acc_phase, setup_phase, wr_en, mapped, data_wr;
  // FIFO state
  logic [7:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [LW-1:0] level, next_level;
  logic ack_tgl, next_ack_tgl, done_seen, next_done_seen;
  logic done_s, pop, fifo_empty, fifo_full;
  // Handshake inputs
  logic [2:0] dma_raw, dma_s, dma_eff;
  logic next_dma_req, tc_seen, next_tc_seen;
  // Transmit side
  ut_state_t state, next_state;
  logic [7:0] shreg, next_shreg;
  logic [3:0] smp, next_smp;
  logic [2:0] bit_idx, next_bit_idx;
  logic stop_cnt, next_stop_cnt, next_txd, done_tgl, next_done_tgl;
  logic [15:0] act_int, next_act_int;
  logic [5:0] act_frac, next_act_frac;
  logic [2:0] act_lcr, next_act_lcr;
  logic ack_s, cts_s, baud_tick, ref_tick, start_ok;
  logic [RW-1:0] ref_cnt, next_ref_cnt;

  // Zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign setup_phase = psel && !penable;
  assign acc_phase = psel && penable;
  assign mapped = paddr == ut_pkg::ADDR_DATA || paddr == ut_pkg::ADDR_STATUS
    || paddr == ut_pkg::ADDR_INT_DIV || paddr == ut_pkg::ADDR_FRAC_DIV
    || paddr == ut_pkg::ADDR_LINE_CTRL || paddr == ut_pkg::ADDR_CTRL;
  assign pslverr = acc_phase && !mapped;
  assign wr_en = acc_phase && pwrite && mapped;
  assign data_wr = wr_en && paddr == ut_pkg::ADDR_DATA && !fifo_full;

  // Register writes land only on the access edge; read data is staged in setup
  always_comb begin
    next_ctrl = ctrl;
    next_lcr = lcr;
    next_int_div = int_div;
    next_frac_div = frac_div;
    next_prdata = prdata;
    if (wr_en) begin
      unique case (paddr)
        ut_pkg::ADDR_CTRL: next_ctrl = pwdata[3:0];
        ut_pkg::ADDR_LINE_CTRL: next_lcr = pwdata[2:0];
        ut_pkg::ADDR_INT_DIV: next_int_div = pwdata[15:0];
        ut_pkg::ADDR_FRAC_DIV: next_frac_div = pwdata[5:0];
        default: next_ctrl = ctrl;
      endcase
    end
    if (setup_phase) begin
      next_prdata = 32'h0000_0000;
      unique case (paddr)
        ut_pkg::ADDR_CTRL: next_prdata[3:0] = ctrl;
        ut_pkg::ADDR_LINE_CTRL: next_prdata[2:0] = lcr;
        ut_pkg::ADDR_INT_DIV: next_prdata[15:0] = int_div;
        ut_pkg::ADDR_FRAC_DIV: next_prdata[5:0] = frac_div;
        ut_pkg::ADDR_STATUS: begin
          next_prdata[ut_pkg::ST_BUSY] = state != UT_IDLE;
          next_prdata[ut_pkg::ST_EMPTY] = fifo_empty;
          next_prdata[ut_pkg::ST_FULL] = fifo_full;
          next_prdata[ut_pkg::ST_RX_CLR] = dma_eff[1];
          next_prdata[ut_pkg::ST_TC] = tc_seen;
          next_prdata[ut_pkg::ST_LEVEL_LSB +: LW] = level;
        end
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= ut_pkg::CTRL_RST;
      lcr <= ut_pkg::LCR_RST;
      int_div <= ut_pkg::INT_DIV_RST;
      frac_div <= ut_pkg::FRAC_DIV_RST;
      prdata <= 32'h0000_0000;
    end else begin
      ctrl <= next_ctrl;
      lcr <= next_lcr;
      int_div <= next_int_div;
      frac_div <= next_frac_div;
      prdata <= next_prdata;
    end
  end

  // DMA clear, receive clear and terminal count from the DMA controller's clock
  assign dma_raw = {dma_terminal_count, rx_dma_req_clear, tx_dma_req_clear};
  ut_sync #(.W(3), .RST(3'h0)) u_dma_sync (
    .clk(pclk), .rst_n(presetn), .d(dma_raw), .q(dma_s));
  // Bypass exists for systems where the DMA controller shares this clock
  assign dma_eff = ctrl[ut_pkg::CTRL_DMA_SYNC] ? dma_s : dma_raw;
  assign rx_dma_clear_synced = dma_eff[1];

  // Request drops on a clear; terminal count holds it off until DMA is re-armed
  always_comb begin
    next_tc_seen = tc_seen;
    if (dma_eff[2]) begin
      next_tc_seen = 1'b1;
    end else if (!ctrl[ut_pkg::CTRL_TX_DMA]) begin
      next_tc_seen = 1'b0;
    end
    next_dma_req = ctrl[ut_pkg::CTRL_TX_DMA] && !fifo_full && !dma_eff[0] && !next_tc_seen;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tc_seen <= 1'b0;
      tx_dma_req <= 1'b0;
    end else begin
      tc_seen <= next_tc_seen;
      tx_dma_req <= next_dma_req;
    end
  end

  // Character-done toggle is the only thing that pops the FIFO
  ut_sync #(.W(1), .RST(1'b0)) u_done_sync (
    .clk(pclk), .rst_n(presetn), .d(done_tgl), .q(done_s));
  assign pop = done_s != done_seen;
  assign fifo_empty = level == '0;
  assign fifo_full = level == LW'(DEPTH);

  always_comb begin
    next_wr_ptr = data_wr ? ptr_inc(wr_ptr) : wr_ptr;
    next_rd_ptr = pop ? ptr_inc(rd_ptr) : rd_ptr;
    next_level = level + LW'(data_wr) - LW'(pop);
    next_done_seen = done_s;
    next_ack_tgl = ack_tgl ^ pop;
  end

  // Storage needs no reset; only pointers and level define its content
  always_ff @(posedge pclk) begin
    if (data_wr) begin
      mem[wr_ptr] <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
      done_seen <= 1'b0;
      ack_tgl <= 1'b0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      level <= next_level;
      done_seen <= next_done_seen;
      ack_tgl <= next_ack_tgl;
    end
  end

  // Reference tick divider stands in for the reference clock rate
  always_comb begin
    next_ref_cnt = (ref_cnt == RW'(REF_DIV - 1) || REF_DIV <= 1) ? '0 : ref_cnt + RW'(1);
  end
  assign ref_tick = ref_cnt == '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cnt <= '0;
    end else begin
      ref_cnt <= next_ref_cnt;
    end
  end

  ut_baud_gen u_baud (
    .clk(pclk), .rst_n(presetn), .ref_tick(ref_tick), .int_div(act_int),
    .frac_div(act_frac), .baud_tick(baud_tick));
  ut_sync #(.W(1), .RST(1'b0)) u_ack_sync (
    .clk(pclk), .rst_n(presetn), .d(ack_tgl), .q(ack_s));
  ut_sync #(.W(1), .RST(1'b1)) u_cts_sync (
    .clk(pclk), .rst_n(presetn), .d(clear_to_send_n), .q(cts_s));

  // Flow control can only narrow the enable, never override a disable
  assign start_ok = ctrl[ut_pkg::CTRL_TX_EN] && !fifo_empty && ack_s == done_tgl
    && (!ctrl[ut_pkg::CTRL_FLOW_EN] || !cts_s);

  // Transmit controller: 16 baud pulses per bit, enable looked at only between characters
  always_comb begin
    next_state = state;
    next_shreg = shreg;
    next_smp = smp;
    next_bit_idx = bit_idx;
    next_stop_cnt = stop_cnt;
    next_txd = txd;
    next_done_tgl = done_tgl;
    next_act_int = act_int;
    next_act_frac = act_frac;
    next_act_lcr = act_lcr;
    unique case (state)
      UT_IDLE: begin
        next_txd = 1'b1;
        next_act_int = int_div;
        next_act_frac = frac_div;
        next_act_lcr = lcr;
        if (start_ok) begin
          next_state = UT_START;
          next_shreg = mem[rd_ptr];
          next_txd = 1'b0;
          next_smp = 4'h0;
        end
      end
      UT_START, UT_DATA, UT_STOP: begin
        if (baud_tick) begin
          next_smp = smp + 4'h1;
          if (smp == ut_pkg::OVERSAMPLE_LAST) begin
            if (state == UT_START) begin
              next_state = UT_DATA;
              next_bit_idx = 3'h0;
              next_txd = shreg[0];
            end else if (state == UT_DATA) begin
              if (bit_idx == ut_pkg::WLEN_BASE_LAST + act_lcr[ut_pkg::LCR_WLEN_LSB +: 2]) begin
                next_state = UT_STOP;
                next_stop_cnt = 1'b0;
                next_txd = 1'b1;
              end else begin
                next_bit_idx = bit_idx + 3'h1;
                next_shreg = {1'b0, shreg[7:1]};
                next_txd = shreg[1];
              end
            end else if (act_lcr[ut_pkg::LCR_TWO_STOP] && !stop_cnt) begin
              next_stop_cnt = 1'b1;
            end else begin
              next_state = UT_DONE;
              next_done_tgl = !done_tgl;
            end
          end
        end
      end
      UT_DONE: begin
        if (ack_s == done_tgl) begin
          next_state = UT_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= UT_IDLE;
      shreg <= 8'h00;
      smp <= 4'h0;
      bit_idx <= 3'h0;
      stop_cnt <= 1'b0;
      txd <= 1'b1;
      done_tgl <= 1'b0;
      act_int <= ut_pkg::INT_DIV_RST;
      act_frac <= ut_pkg::FRAC_DIV_RST;
      act_lcr <= ut_pkg::LCR_RST;
    end else begin
      state <= next_state;
      shreg <= next_shreg;
      smp <= next_smp;
      bit_idx <= next_bit_idx;
      stop_cnt <= next_stop_cnt;
      txd <= next_txd;
      done_tgl <= next_done_tgl;
      act_int <= next_act_int;
      act_frac <= next_act_frac;
      act_lcr <= next_act_lcr;
    end
  end

  sequence s_char_done;
    $changed(done_tgl);
  endsequence
  sequence s_busy_two;
    state != UT_IDLE ##1 state != UT_IDLE;
  endsequence

  a_dma_sync_path: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl[ut_pkg::CTRL_DMA_SYNC] ##2 ctrl[ut_pkg::CTRL_DMA_SYNC]
    |-> dma_eff[0] == $past(tx_dma_req_clear, 2)) else $error("clear not synchronised");
  a_dma_bypass: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl[ut_pkg::CTRL_DMA_SYNC] |-> dma_eff == dma_raw) else $error("bypass wrong");
  a_req_cleared: assert property (@(posedge pclk) disable iff (!presetn)
    dma_eff[0] || dma_eff[2] |=> !tx_dma_req) else $error("request survived clear");
  a_no_start_off: assert property (@(posedge pclk) disable iff (!presetn)
    state == UT_IDLE && !ctrl[ut_pkg::CTRL_TX_EN] |=> state == UT_IDLE)
    else $error("start while disabled");
  a_flow_hold: assert property (@(posedge pclk) disable iff (!presetn)
    state == UT_IDLE && ctrl[ut_pkg::CTRL_FLOW_EN] && cts_s |=> state == UT_IDLE)
    else $error("start without clear to send");
  a_char_finish: assert property (@(posedge pclk) disable iff (!presetn)
    state == UT_DATA |=> state != UT_IDLE) else $error("character cut short");
  a_pop_after_done: assert property (@(posedge pclk) disable iff (!presetn)
    s_char_done |-> !pop ##2 pop) else $error("pop not two cycles after done");
  a_ack_wait: assert property (@(posedge pclk) disable iff (!presetn)
    state == UT_DONE && ack_s != done_tgl |=> state == UT_DONE)
    else $error("left done before pop acknowledged");
  a_div_hold: assert property (@(posedge pclk) disable iff (!presetn)
    s_busy_two |-> $stable(act_int) && $stable(act_frac) && $stable(act_lcr))
    else $error("divisor changed mid character");
endmodule : ut_tx_top
`default_nettype wire

// ==== verif/ut_far_end.sv ====
// Far-end model: serial receiver, clear-to-send source and DMA clear responder
`timescale 1ns/10ps
`default_nettype none
module ut_far_end (
  input wire logic pclk,
  input wire logic txd,
  input wire logic tx_dma_req,
  input wire logic cts_hold,
  input wire logic dma_on,
  input wire logic [15:0] bit_cyc,
  output logic clear_to_send_n,
  output logic tx_dma_req_clear,
  output logic [7:0] rx_byte,
  output logic rx_stb
);
  // Clear-to-send follows the bench's cts_hold input directly; no receiver state drives it
  assign clear_to_send_n = cts_hold;

  // Receiver samples mid-bit, LSB first; a frame without stop bit is not reported
  initial begin
    rx_byte = 8'h00;
    rx_stb = 1'b0;
    forever begin
      @(negedge txd);
      repeat (bit_cyc / 2) @(posedge pclk);
      for (int i = 0; i < 8; i++) begin
        repeat (bit_cyc) @(posedge pclk);
        rx_byte[i] <= txd;
      end
      repeat (bit_cyc) @(posedge pclk);
      rx_stb <= txd;
      @(posedge pclk);
      rx_stb <= 1'b0;
    end
  end

  // DMA answers a request after two cycles, holds clear until the request drops
  initial begin
    tx_dma_req_clear = 1'b0;
    forever begin
      @(posedge pclk);
      if (dma_on && tx_dma_req) begin
        repeat (2) @(posedge pclk);
        tx_dma_req_clear <= 1'b1;
        for (int k = 0; k < 50 && tx_dma_req; k++) @(posedge pclk);
        tx_dma_req_clear <= 1'b0;
      end
    end
  end
endmodule : ut_far_end
`default_nettype wire

// ==== verif/ut_tx_top_tb.sv ====
// Self-checking bench for the transmitter: registers, framing, baud, flow control, DMA
`timescale 1ns/10ps
`default_nettype none
module ut_tx_top_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, txd, cts_n, cts_hold;
  logic tx_dma_req, far_clr, rx_clr, tc, rx_clr_s, dma_on, rx_stb, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [15:0] bit_cyc;
  logic [7:0] rx_byte, b[6];
  logic [7:0] rxq[$];
  int err_total, checks_done, n, f, w, base;
  real dv;
  real dtab[4] = '{2.0, 2.25, 2.5, 2.984375};

  ut_tx_top #(.DEPTH(16), .REF_DIV(1)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .clear_to_send_n(cts_n), .txd(txd),
    .tx_dma_req(tx_dma_req), .tx_dma_req_clear(far_clr), .rx_dma_req_clear(rx_clr),
    .dma_terminal_count(tc), .rx_dma_clear_synced(rx_clr_s));
  ut_far_end far (.pclk(pclk), .txd(txd), .tx_dma_req(tx_dma_req), .cts_hold(cts_hold),
    .dma_on(dma_on), .bit_cyc(bit_cyc), .clear_to_send_n(cts_n),
    .tx_dma_req_clear(far_clr), .rx_byte(rx_byte), .rx_stb(rx_stb));

  always #5 pclk = ~pclk;
  // Collect every reported frame in arrival order
  always @(posedge pclk) if (rx_stb === 1'b1) rxq.push_back(rx_byte);

  task summarize;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  // Start alignment to the baud tick leaves up to one period of slack
  task chk_near(input string nm, input int e, input int g, input int tol);
    checks_done++;
    if (g < e - tol || g > e + tol) begin
      err_total++;
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_near
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    bit ok;
    ok = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int k = 0; k < 20 && !ok; k++) begin
      @(posedge pclk);
      ok = (pready === 1'b1);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (!ok) begin
      err_total++;
      summarize;
    end
  endtask : apb
  task wait_low;
    for (int k = 0; k < 4000 && txd !== 1'b0; k++) @(posedge pclk);
    if (txd !== 1'b0) begin
      err_total++;
      summarize;
    end
  endtask : wait_low
  task meas_low(output int c);
    wait_low;
    c = 0;
    while (txd === 1'b0 && c < 5000) begin
      @(posedge pclk);
      c++;
    end
    if (txd === 1'b0) begin
      err_total++;
      summarize;
    end
  endtask : meas_low
  task wait_q(input int cnt);
    for (int k = 0; k < 20000 && rxq.size() < cnt; k++) @(posedge pclk);
    if (rxq.size() < cnt) begin
      err_total++;
      summarize;
    end
  endtask : wait_q
  // Cycles from the clear reaching the block until the request drops
  task dma_lat(output int c);
    c = 0;
    for (int k = 0; k < 200 && far_clr !== 1'b1; k++) @(negedge pclk);
    if (far_clr !== 1'b1) begin
      err_total++;
      summarize;
    end
    while (tx_dma_req === 1'b1 && c < 20) begin
      c++;
      @(negedge pclk);
    end
  endtask : dma_lat
  function automatic logic [5:0] frac_field(input real fr);
    return 6'($rtoi(fr * 64.0 + 0.5));
  endfunction : frac_field
  function automatic int low_exp(input int dn, input int df, input int bits);
    return (bits * 16 * (64 * dn + df)) / 64;
  endfunction : low_exp

  initial begin
    repeat (100000) @(posedge pclk);
    err_total++;
    summarize;
  end

  initial begin
    {pclk, presetn, psel, penable, pwrite, rx_clr, tc, cts_hold, dma_on} = '0;
    paddr = 12'h000;
    pwdata = 32'h0;
    bit_cyc = 16'h0020;
    void'($urandom(44358));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, ut_pkg::ADDR_CTRL, 0);
    chk("ctrl reset", 32'h5, rdat);
    apb(0, ut_pkg::ADDR_LINE_CTRL, 0);
    chk("line reset", 32'h3, rdat);
    apb(0, ut_pkg::ADDR_INT_DIV, 0);
    chk("int reset", 32'h0, rdat);
    apb(0, ut_pkg::ADDR_FRAC_DIV, 0);
    chk("frac reset", 32'h0, rdat);
    apb(0, 12'h040, 0);
    chk("unmapped err", 32'h1, {31'h0, rerr});
    // Fraction sweep: fixed corners, then one drawn at random
    for (int i = 0; i < 5; i++) begin
      dv = (i < 4) ? dtab[i] : 2.0 + ($urandom % 64) / 64.0;
      n = $rtoi(dv);
      f = frac_field(dv - n);
      apb(1, ut_pkg::ADDR_INT_DIV, 32'(n));
      apb(1, ut_pkg::ADDR_FRAC_DIV, 32'(f));
      bit_cyc = 16'(low_exp(n, f, 1));
      apb(1, ut_pkg::ADDR_DATA, 32'h0);
      meas_low(w);
      chk_near("low run", low_exp(n, f, 9), w, n + 1);
      wait_q(i + 1);
      chk("frac byte", 32'h0, rxq[i]);
    end
    apb(1, ut_pkg::ADDR_FRAC_DIV, 32'h0);
    apb(1, ut_pkg::ADDR_INT_DIV, 32'h2);
    bit_cyc = 16'h0020;
    // Divisor written mid-character must wait for the character to end
    apb(1, ut_pkg::ADDR_DATA, 32'h0);
    fork
      meas_low(w);
      begin
        repeat (60) @(posedge pclk);
        apb(1, ut_pkg::ADDR_INT_DIV, 32'h3);
      end
    join
    chk_near("old divisor run", low_exp(2, 0, 9), w, 3);
    wait_q(6);
    bit_cyc = 16'h0030;
    apb(1, ut_pkg::ADDR_DATA, 32'h0);
    meas_low(w);
    chk_near("new divisor run", low_exp(3, 0, 9), w, 4);
    wait_q(7);
    apb(1, ut_pkg::ADDR_INT_DIV, 32'h2);
    bit_cyc = 16'h0020;
    // Five data bits, two stop bits; the receiver reads stop and idle as ones
    apb(1, ut_pkg::ADDR_LINE_CTRL, 32'h4);
    apb(1, ut_pkg::ADDR_DATA, 32'h0);
    meas_low(w);
    chk_near("short word run", low_exp(2, 0, 6), w, 3);
    wait_q(8);
    chk("short word byte", 32'hE0, rxq[7]);
    apb(1, ut_pkg::ADDR_LINE_CTRL, 32'h3);
    foreach (b[i]) b[i] = 8'($urandom);
    // Disable during a character, then re-enable
    base = rxq.size();
    apb(1, ut_pkg::ADDR_DATA, {24'h0, b[0]});
    apb(1, ut_pkg::ADDR_DATA, {24'h0, b[1]});
    wait_low;
    apb(1, ut_pkg::ADDR_CTRL, 32'h4);
    repeat (1000) @(posedge pclk);
    chk("count after disable", base + 1, rxq.size());
    chk("byte before disable", b[0], rxq[base]);
    apb(0, ut_pkg::ADDR_STATUS, 0);
    chk("paused status", 32'h100, {16'h0, rdat[15:0]});
    apb(1, ut_pkg::ADDR_CTRL, 32'h5);
    wait_q(base + 2);
    repeat (600) @(posedge pclk);
    chk("count after enable", base + 2, rxq.size());
    chk("resumed byte", b[1], rxq[base + 1]);
    // Flow control holds off, and never overrides a disable
    cts_hold <= 1'b1;
    apb(1, ut_pkg::ADDR_CTRL, 32'h7);
    apb(1, ut_pkg::ADDR_DATA, {24'h0, b[2]});
    repeat (600) @(posedge pclk);
    chk("count cts high", base + 2, rxq.size());
    apb(1, ut_pkg::ADDR_CTRL, 32'h6);
    cts_hold <= 1'b0;
    repeat (600) @(posedge pclk);
    chk("count disabled", base + 2, rxq.size());
    apb(1, ut_pkg::ADDR_CTRL, 32'h7);
    wait_q(base + 3);
    chk("flow byte", b[2], rxq[base + 2]);
    // Back-to-back burst must come out once each, in order
    for (int i = 3; i < 6; i++) apb(1, ut_pkg::ADDR_DATA, {24'h0, b[i]});
    wait_q(base + 6);
    for (int i = 3; i < 6; i++) chk("burst byte", b[i], rxq[base + i]);
    repeat (300) @(posedge pclk);
    chk("queue length", base + 6, rxq.size());
    // Seventeen writes into a paused FIFO: the last one finds it full and is dropped
    apb(1, ut_pkg::ADDR_CTRL, 32'h4);
    for (int i = 0; i < 17; i++) apb(1, ut_pkg::ADDR_DATA, 32'(i));
    apb(0, ut_pkg::ADDR_STATUS, 0);
    chk("full status", 32'h1004, {16'h0, rdat[15:0]});
    apb(1, ut_pkg::ADDR_CTRL, 32'h5);
    wait_q(base + 22);
    repeat (600) @(posedge pclk);
    chk("count after full", base + 22, rxq.size());
    chk("last kept byte", 32'hF, rxq[base + 21]);
    apb(0, ut_pkg::ADDR_STATUS, 0);
    chk("idle status", 32'h2, {16'h0, rdat[15:0]});
    // DMA clear latency with synchroniser on, then bypassed
    apb(1, ut_pkg::ADDR_CTRL, 32'hD);
    dma_on <= 1'b1;
    dma_lat(n);
    chk("sync clear latency", 32'(3), 32'(n));
    dma_on <= 1'b0;
    repeat (60) @(posedge pclk);
    apb(1, ut_pkg::ADDR_CTRL, 32'h9);
    dma_on <= 1'b1;
    dma_lat(n);
    chk("bypass clear latency", 32'(1), 32'(n));
    dma_on <= 1'b0;
    repeat (60) @(posedge pclk);
    apb(1, ut_pkg::ADDR_CTRL, 32'h5);
    @(posedge pclk);
    rx_clr <= 1'b1;
    repeat (2) @(negedge pclk);
    chk("rx clear early", 32'h0, {31'h0, rx_clr_s});
    @(negedge pclk);
    chk("rx clear synced", 32'h1, {31'h0, rx_clr_s});
    @(posedge pclk);
    rx_clr <= 1'b0;
    apb(1, ut_pkg::ADDR_CTRL, 32'h1);
    @(posedge pclk);
    rx_clr <= 1'b1;
    @(negedge pclk);
    chk("rx clear bypass", 32'h1, {31'h0, rx_clr_s});
    @(posedge pclk);
    rx_clr <= 1'b0;
    // Terminal count latches the request off until the DMA enable is cycled
    apb(1, ut_pkg::ADDR_CTRL, 32'hD);
    repeat (4) @(posedge pclk);
    chk("dma req on", 32'h1, {31'h0, tx_dma_req});
    tc <= 1'b1;
    repeat (2) @(posedge pclk);
    tc <= 1'b0;
    repeat (10) @(posedge pclk);
    chk("dma req after tc", 32'h0, {31'h0, tx_dma_req});
    apb(0, ut_pkg::ADDR_STATUS, 0);
    chk("tc flag", 32'h1, {31'h0, rdat[ut_pkg::ST_TC]});
    apb(1, ut_pkg::ADDR_CTRL, 32'h5);
    apb(1, ut_pkg::ADDR_CTRL, 32'hD);
    repeat (4) @(posedge pclk);
    chk("dma req rearmed", 32'h1, {31'h0, tx_dma_req});
    summarize;
  end
endmodule : ut_tx_top_tb
`default_nettype wire
